// ==== core/rt_integ_defines.vh ====
`ifndef RT_INTEG_DEFINES_VH
`define RT_INTEG_DEFINES_VH

// build size: number of measurement elements
`define ELEM_NUM 6
`define ELEM_IDX_W 3

// register byte offsets
`define REG_CTRL 6'h00
`define REG_CMD 6'h04
`define REG_TIMER 6'h08
`define REG_START_DATE 6'h0C
`define REG_START_TIME 6'h10
`define REG_STOP_DATE 6'h14
`define REG_STOP_TIME 6'h18
`define REG_STATUS 6'h1C
`define REG_MASK 6'h20
`define REG_STATE 6'h24
`define REG_ELAPSED 6'h28
`define REG_VALUE 6'h2C

// control register fields
`define CTRL_REPEAT 0
`define CTRL_INDEP 1
`define CTRL_ALL 2
`define CTRL_SEL_LSB 4
`define CTRL_SEL_MSB 6

// command register bits (write only, self clearing)
`define CMD_LAUNCH 0
`define CMD_STOP 1
`define CMD_RESET 2

// status / mask bits
`define ST_DONE 0
`define ST_RESTART 1
`define ST_DATE_ERR 2
`define ST_PARAM_ERR 3
`define ST_W 4

// h:m:s word layout, used by timer and elapsed time
`define HMS_SEC_LSB 0
`define HMS_MIN_LSB 6
`define HMS_HOUR_LSB 12
`define HMS_W 26

// date word {year[11:0], month[3:0], day[4:0]}, time word {hour, min, sec}
`define DATE_W 21
`define TIME_W 17

// limits
`define HOUR_MAX 14'h2710
`define ACC_W 24
`define ACC_LIMIT 24'h0F_423F

// reset values
`define RST_DATE 21'h0F_A221
`define RST_TIME 17'h0_0000
`define RST_TIMER 26'h000_0000

`endif

// ==== core/rt_integ_sched.v ====
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "rt_integ_defines.vh"

module rt_integ_sched (
   input wire core_clk,
   input wire rst,
   input wire [5:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   input wire now_tick,
   input wire [`DATE_W-1:0] now_date,
   input wire [`TIME_W-1:0] now_time,
   input wire sample_valid,
   input wire [`ACC_W-1:0] sample_delta,
   output reg [`ELEM_NUM-1:0] running_q,
   output reg [`ELEM_NUM-1:0] held_q,
   output reg irq_q
);

   localparam N = `ELEM_NUM;
   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_ARMED = 4'b0010;
   localparam [3:0] S_RUN = 4'b0100;
   localparam [3:0] S_HELD = 4'b1000;

   // leap rule applied only when a launch evaluates the date
   function date_ok;
      input [`DATE_W-1:0] d;
      reg [11:0] y;
      reg [3:0] m;
      reg [4:0] dd;
      reg leap;
      reg [4:0] dmax;
      begin
         y = d[20:9];
         m = d[8:5];
         dd = d[4:0];
         leap = (y[1:0] == 2'b00) && ((y % 12'd100 != 12'd0) || (y % 12'd400 == 12'd0));
         case (m)
            4'd2: dmax = leap ? 5'd29 : 5'd28;
            4'd4, 4'd6, 4'd9, 4'd11: dmax = 5'd30;
            default: dmax = 5'd31;
         endcase
         date_ok = (m >= 4'd1) && (m <= 4'd12) && (dd >= 5'd1) && (dd <= dmax);
      end
   endfunction

   // one second step of an h:m:s counter
   function [`HMS_W-1:0] hms_inc;
      input [`HMS_W-1:0] t;
      reg [5:0] s;
      reg [5:0] mi;
      reg [13:0] h;
      begin
         s = t[5:0];
         mi = t[11:6];
         h = t[25:12];
         if (s == 6'd59) begin
            s = 6'd0;
            if (mi == 6'd59) begin
               mi = 6'd0;
               h = h + 14'd1;
            end else begin
               mi = mi + 6'd1;
            end
         end else begin
            s = s + 6'd1;
         end
         hms_inc = {h, mi, s};
      end
   endfunction

   // control and command decode
   reg [`CTRL_SEL_MSB:0] ctrl_q;
   reg [`ST_W-1:0] status_q;
   reg [`ST_W-1:0] mask_q;
   reg [`HMS_W-1:0] tmr_sh_q;
   reg [`DATE_W-1:0] sd_sh_q;
   reg [`TIME_W-1:0] st_sh_q;
   reg [`DATE_W-1:0] ed_sh_q;
   reg [`TIME_W-1:0] et_sh_q;
   reg [`HMS_W-1:0] tmr_arr [0:N-1];
   reg [`DATE_W-1:0] sd_arr [0:N-1];
   reg [`TIME_W-1:0] st_arr [0:N-1];
   reg [`DATE_W-1:0] ed_arr [0:N-1];
   reg [`TIME_W-1:0] et_arr [0:N-1];
   reg [`HMS_W-1:0] elap_arr [0:N-1];
   reg [`ACC_W-1:0] acc_arr [0:N-1];
   reg [N-1:0] done_ev;
   reg [N-1:0] rest_ev;

   wire wr_go = write && !waitrequest;
   wire req_new = (read || write) && waitrequest;
   // a one-element build has no per-element control at all
   wire indep = (N > 1) && ctrl_q[`CTRL_INDEP];
   wire all_sel = ctrl_q[`CTRL_ALL];
   wire [`ELEM_IDX_W-1:0] sel = ctrl_q[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
   wire repeat_mode = ctrl_q[`CTRL_REPEAT];
   wire cmd_wr = wr_go && (address == `REG_CMD);
   wire launch = cmd_wr && writedata[`CMD_LAUNCH];
   wire stop_cmd = cmd_wr && writedata[`CMD_STOP];
   wire reset_cmd = cmd_wr && writedata[`CMD_RESET];

   // range checks on written values; bad writes are dropped
   wire [13:0] w_hour = writedata[25:12];
   wire hms_ok = (writedata[11:6] <= 6'd59) && (writedata[5:0] <= 6'd59);
   wire tmr_ok = hms_ok && ((w_hour < `HOUR_MAX) ||
                 ((w_hour == `HOUR_MAX) && (writedata[11:0] == 12'h000)));
   wire time_ok = (writedata[16:12] <= 5'd23) && hms_ok;
   // february up to 31 is stored as written; calendar check waits for launch
   wire wdate_ok = (writedata[8:5] >= 4'd1) && (writedata[8:5] <= 4'd12) &&
                   (writedata[4:0] >= 5'd1);
   wire is_tmr = wr_go && (address == `REG_TIMER);
   wire is_sd = wr_go && (address == `REG_START_DATE);
   wire is_st = wr_go && (address == `REG_START_TIME);
   wire is_ed = wr_go && (address == `REG_STOP_DATE);
   wire is_et = wr_go && (address == `REG_STOP_TIME);
   wire param_bad = (is_tmr && !tmr_ok) || ((is_st || is_et) && !time_ok) ||
                    ((is_sd || is_ed) && !wdate_ok);
   // shared copy follows element one, or any broadcast write
   wire sh_hit = !indep || all_sel || (sel == {`ELEM_IDX_W{1'b0}});

   // launch validation over every element's effective reservation
   reg launch_bad;
   integer k;
   always @* begin
      launch_bad = 1'b0;
      for (k = 0; k < N; k = k + 1) begin
         if (indep) begin
            if (!date_ok(sd_arr[k]) || !date_ok(ed_arr[k]))
               launch_bad = 1'b1;
         end else begin
            if (!date_ok(sd_sh_q) || !date_ok(ed_sh_q))
               launch_bad = 1'b1;
         end
      end
   end
   wire launch_ok = launch && !launch_bad;

   // bus handshake: one wait cycle, answer on the second
   always @(posedge core_clk) begin
      if (rst) begin
         waitrequest <= 1'b1;
      end else if (req_new) begin
         waitrequest <= 1'b0;
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // control, mask and shared settings
   always @(posedge core_clk) begin
      if (rst) begin
         ctrl_q <= {(`CTRL_SEL_MSB+1){1'b0}};
         mask_q <= {`ST_W{1'b0}};
         tmr_sh_q <= `RST_TIMER;
         sd_sh_q <= `RST_DATE;
         st_sh_q <= `RST_TIME;
         ed_sh_q <= `RST_DATE;
         et_sh_q <= `RST_TIME;
      end else if (wr_go) begin
         if (address == `REG_CTRL)
            ctrl_q <= writedata[`CTRL_SEL_MSB:0];
         if (address == `REG_MASK)
            mask_q <= writedata[`ST_W-1:0];
         if (is_tmr && tmr_ok && sh_hit)
            tmr_sh_q <= writedata[`HMS_W-1:0];
         if (is_sd && wdate_ok && sh_hit)
            sd_sh_q <= writedata[`DATE_W-1:0];
         if (is_st && time_ok && sh_hit)
            st_sh_q <= writedata[`TIME_W-1:0];
         if (is_ed && wdate_ok && sh_hit)
            ed_sh_q <= writedata[`DATE_W-1:0];
         if (is_et && time_ok && sh_hit)
            et_sh_q <= writedata[`TIME_W-1:0];
      end
   end

   // sticky status: hardware set wins over a same-cycle write-one clear
   always @(posedge core_clk) begin
      if (rst) begin
         status_q <= {`ST_W{1'b0}};
      end else begin
         status_q <= (status_q & ~((wr_go && address == `REG_STATUS) ?
                      writedata[`ST_W-1:0] : {`ST_W{1'b0}}))
                     | {param_bad, launch && launch_bad, |rest_ev, |done_ev};
      end
   end

   // level interrupt from unmasked status
   always @(posedge core_clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   wire [`DATE_W+`TIME_W-1:0] now_stamp = {now_date, now_time};

   // per-element settings, run state, elapsed time and accumulation
   genvar e;
   generate
      for (e = 0; e < N; e = e + 1) begin : g_elem
         reg [3:0] state_q;
         // single-element control writes only element one when shared
         wire el_hit = indep ? (all_sel || ({{(32-`ELEM_IDX_W){1'b0}}, sel} == e)) :
                       (e == 0);
         wire [`HMS_W-1:0] tmr = indep ? tmr_arr[e] : tmr_sh_q;
         wire [`DATE_W+`TIME_W-1:0] t_start = indep ? {sd_arr[e], st_arr[e]} :
                                              {sd_sh_q, st_sh_q};
         wire [`DATE_W+`TIME_W-1:0] t_stop = indep ? {ed_arr[e], et_arr[e]} :
                                             {ed_sh_q, et_sh_q};
         wire [`HMS_W-1:0] el_next = hms_inc(elap_arr[e]);
         wire at_ceiling = (elap_arr[e] == {`HOUR_MAX, 12'h000});
         wire tmr_zero = (tmr == `RST_TIMER);
         wire tmr_hit = !tmr_zero && (el_next == tmr);
         wire [`ACC_W:0] acc_sum = {acc_arr[e][`ACC_W-1], acc_arr[e]} +
                                   {sample_delta[`ACC_W-1], sample_delta};
         wire hi_lim = !acc_sum[`ACC_W] && (acc_sum >= {1'b0, `ACC_LIMIT});
         wire lo_lim = acc_sum[`ACC_W] &&
                       (acc_sum <= (~{1'b0, `ACC_LIMIT} + {{`ACC_W{1'b0}}, 1'b1}));

         // settings for this element
         always @(posedge core_clk) begin
            if (rst) begin
               tmr_arr[e] <= `RST_TIMER;
               sd_arr[e] <= `RST_DATE;
               st_arr[e] <= `RST_TIME;
               ed_arr[e] <= `RST_DATE;
               et_arr[e] <= `RST_TIME;
            end else if (el_hit) begin
               if (is_tmr && tmr_ok)
                  tmr_arr[e] <= writedata[`HMS_W-1:0];
               if (is_sd && wdate_ok)
                  sd_arr[e] <= writedata[`DATE_W-1:0];
               if (is_st && time_ok)
                  st_arr[e] <= writedata[`TIME_W-1:0];
               if (is_ed && wdate_ok)
                  ed_arr[e] <= writedata[`DATE_W-1:0];
               if (is_et && time_ok)
                  et_arr[e] <= writedata[`TIME_W-1:0];
            end
         end

         // run control; held values only leave through the reset command
         always @(posedge core_clk) begin
            if (rst) begin
               state_q <= S_IDLE;
               elap_arr[e] <= `RST_TIMER;
               acc_arr[e] <= {`ACC_W{1'b0}};
               done_ev[e] <= 1'b0;
               rest_ev[e] <= 1'b0;
            end else begin
               done_ev[e] <= 1'b0;
               rest_ev[e] <= 1'b0;
               if (reset_cmd) begin
                  state_q <= S_IDLE;
                  elap_arr[e] <= `RST_TIMER;
                  acc_arr[e] <= {`ACC_W{1'b0}};
               end else begin
                  case (state_q)
                     S_IDLE: begin
                        if (launch_ok) begin
                           state_q <= S_ARMED;
                           elap_arr[e] <= `RST_TIMER;
                           acc_arr[e] <= {`ACC_W{1'b0}};
                        end
                     end
                     S_ARMED: begin
                        if (stop_cmd || now_stamp >= t_stop) begin
                           state_q <= S_HELD;
                           done_ev[e] <= 1'b1;
                        end else if (now_stamp >= t_start) begin
                           state_q <= S_RUN;
                        end
                     end
                     S_RUN: begin
                        if (stop_cmd || now_stamp >= t_stop) begin
                           state_q <= S_HELD;
                           done_ev[e] <= 1'b1;
                        end else begin
                           // limit check precedes the timer so an overrun never restarts
                           if (sample_valid) begin
                              if (hi_lim || lo_lim) begin
                                 acc_arr[e] <= hi_lim ? `ACC_LIMIT :
                                               (~`ACC_LIMIT + 24'h00_0001);
                                 state_q <= S_HELD;
                                 done_ev[e] <= 1'b1;
                              end else begin
                                 acc_arr[e] <= acc_sum[`ACC_W-1:0];
                              end
                           end
                           if (now_tick && !(sample_valid && (hi_lim || lo_lim))) begin
                              if (at_ceiling) begin
                                 state_q <= S_HELD;
                                 done_ev[e] <= 1'b1;
                              end else if (tmr_hit && repeat_mode) begin
                                 elap_arr[e] <= `RST_TIMER;
                                 acc_arr[e] <= {`ACC_W{1'b0}};
                                 rest_ev[e] <= 1'b1;
                              end else if (tmr_hit) begin
                                 elap_arr[e] <= el_next;
                                 state_q <= S_HELD;
                                 done_ev[e] <= 1'b1;
                              end else begin
                                 elap_arr[e] <= el_next;
                              end
                           end
                        end
                     end
                     S_HELD: begin
                        state_q <= S_HELD;
                     end
                     default: begin
                        state_q <= S_IDLE;
                     end
                  endcase
               end
            end
         end

         // state flags for the pins
         always @(posedge core_clk) begin
            if (rst) begin
               running_q[e] <= 1'b0;
               held_q[e] <= 1'b0;
            end else begin
               running_q[e] <= (state_q == S_RUN);
               held_q[e] <= (state_q == S_HELD);
            end
         end
      end
   endgenerate

   // readback of shared or selected element values
   reg [31:0] rd_mux;
   wire [`ELEM_IDX_W-1:0] rsel = indep ? sel : {`ELEM_IDX_W{1'b0}};
   always @* begin
      case (address)
         `REG_CTRL: rd_mux = {25'h000_0000, ctrl_q};
         `REG_TIMER: rd_mux = {6'h00, indep ? tmr_arr[rsel] : tmr_sh_q};
         `REG_START_DATE: rd_mux = {11'h000, indep ? sd_arr[rsel] : sd_sh_q};
         `REG_START_TIME: rd_mux = {15'h0000, indep ? st_arr[rsel] : st_sh_q};
         `REG_STOP_DATE: rd_mux = {11'h000, indep ? ed_arr[rsel] : ed_sh_q};
         `REG_STOP_TIME: rd_mux = {15'h0000, indep ? et_arr[rsel] : et_sh_q};
         `REG_STATUS: rd_mux = {28'h000_0000, status_q};
         `REG_MASK: rd_mux = {28'h000_0000, mask_q};
         `REG_STATE: rd_mux = {20'h0_0000, held_q, running_q};
         `REG_ELAPSED: rd_mux = {6'h00, elap_arr[rsel]};
         `REG_VALUE: rd_mux = {{8{acc_arr[rsel][`ACC_W-1]}}, acc_arr[rsel]};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data captured in the wait cycle, stands at the answer edge
   always @(posedge core_clk) begin
      if (rst) begin
         readdata <= 32'h0000_0000;
      end else if (req_new && read) begin
         readdata <= rd_mux;
      end
   end

endmodule

// ==== test/rt_integ_checker.sv ====
`timescale 1ns/1ns
`include "rt_integ_defines.vh"
module rt_integ_checker (
   input wire core_clk,
   input wire rst,
   input wire [5:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire [`ELEM_NUM-1:0] running_q,
   input wire [`ELEM_NUM-1:0] held_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire acc_w = write && !waitrequest;
   wire clr_cmd = acc_w && address == `REG_CMD && writedata[`CMD_RESET];
   wire go_cmd = acc_w && address == `REG_CMD && writedata[`CMD_LAUNCH];
   reg armed_q;
   // remembers that a launch was taken; a reset command forgets it
   always @(posedge core_clk) begin
      if (rst || clr_cmd)
         armed_q <= 1'b0;
      else if (go_cmd)
         armed_q <= 1'b1;
   end
   sequence bus_req;
      (read || write) && waitrequest;
   endsequence
   sequence bus_ack;
      !waitrequest ##1 waitrequest;
   endsequence
   chk_bus_answer: assert property (bus_req |=> bus_ack)
      else $error("bus request not answered in one cycle");
   chk_bus_quiet: assert property (!read && !write && waitrequest |=> waitrequest)
      else $error("bus accepted without a request");
   // readdata may only move at the edge that captures a read
   chk_read_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
      else $error("readdata changed without a read");
   chk_unmapped_zero: assert property (read && !waitrequest && address > `REG_VALUE
      |-> readdata == 32'h0000_0000) else $error("unmapped read not zero");
   chk_cmd_zero: assert property (read && !waitrequest && address == `REG_CMD
      |-> readdata == 32'h0000_0000) else $error("command register read not zero");
   chk_run_held_excl: assert property ((running_q & held_q) == 6'h00)
      else $error("element running and held at once");
   chk_run_launch: assert property (running_q != 6'h00 |-> armed_q || $past(armed_q))
      else $error("element running without launch");
   chk_held_keeps: assert property (!clr_cmd && !$past(clr_cmd)
      |=> (held_q & $past(held_q)) == $past(held_q)) else $error("held element released");
   chk_reset_clears: assert property (clr_cmd |-> ##2 (running_q == 6'h00 && held_q == 6'h00))
      else $error("reset command did not clear");
endmodule
bind rt_integ_sched rt_integ_checker chk_u (.core_clk(core_clk), .rst(rst), .address(address),
   .read(read), .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .running_q(running_q), .held_q(held_q));

// ==== test/cal_source.sv ====
`timescale 1ns/1ns
`include "rt_integ_defines.vh"
module cal_source #(parameter int TICK_DIV = 8) (
   input wire core_clk,
   input wire rst,
   input wire restart,
   input wire [`DATE_W-1:0] date_in,
   input wire [`ACC_W-1:0] delta,
   output reg now_tick,
   output reg [`DATE_W-1:0] now_date,
   output reg [`TIME_W-1:0] now_time,
   output reg sample_valid,
   output reg [`ACC_W-1:0] sample_delta
);
   reg [7:0] div_q;
   // seconds only count up; each run restarts the clock so it stays within a minute
   // samples land mid-second so they never race a tick
   always @(posedge core_clk) begin
      now_tick <= 1'b0;
      sample_valid <= 1'b0;
      sample_delta <= ~sample_delta;
      if (rst || restart) begin
         div_q <= 8'h00;
         now_time <= 17'h0_0000;
         now_date <= date_in;
         sample_delta <= 24'h00_0000;
      end else begin
         div_q <= (div_q == TICK_DIV - 1) ? 8'h00 : div_q + 8'h01;
         if (div_q == TICK_DIV - 1) begin
            now_tick <= 1'b1;
            now_time <= now_time + 17'h0_0001;
         end
         if (div_q == TICK_DIV / 2) begin
            sample_valid <= 1'b1;
            sample_delta <= delta;
         end
      end
   end
endmodule

// ==== test/tb_rt_integ_sched.sv ====
`timescale 1ns/1ns
`include "rt_integ_defines.vh"
module tb_rt_integ_sched;
   reg core_clk = 1'b0;
   reg rst = 1'b1;
   reg [5:0] address = 6'h00;
   reg read = 1'b0;
   reg write = 1'b0;
   reg [31:0] writedata = 32'h0000_0000;
   reg restart = 1'b0;
   reg [`DATE_W-1:0] date_in = 21'h0F_A85D;
   reg [`ACC_W-1:0] delta = 24'h00_0003;
   wire [31:0] readdata;
   wire waitrequest;
   wire now_tick;
   wire [`DATE_W-1:0] now_date;
   wire [`TIME_W-1:0] now_time;
   wire sample_valid;
   wire [`ACC_W-1:0] sample_delta;
   wire [5:0] running_q;
   wire [5:0] held_q;
   wire irq_q;
   integer n_fail = 0;
   integer check_count = 0;
   integer cyc = 0;
   integer i;
   reg [31:0] rd_q;
   localparam [31:0] T_MAX = {6'h00, 14'h2710, 12'h000};
   always #5 core_clk = ~core_clk;
   rt_integ_sched dut_u (.core_clk(core_clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .now_tick(now_tick), .now_date(now_date), .now_time(now_time),
      .sample_valid(sample_valid), .sample_delta(sample_delta), .running_q(running_q),
      .held_q(held_q), .irq_q(irq_q));
   cal_source cal_u (.core_clk(core_clk), .rst(rst), .restart(restart), .date_in(date_in),
      .delta(delta), .now_tick(now_tick), .now_date(now_date), .now_time(now_time),
      .sample_valid(sample_valid), .sample_delta(sample_delta));
   task end_of_test;
      begin
         $display("mismatches %0d of %0d checks", n_fail, check_count);
         if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one bus access; held until waitrequest is seen low, data taken at that edge
   task bus(input rw, input [5:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge core_clk);
         address <= a;
         writedata <= d;
         read <= !rw;
         write <= rw;
         n = 0;
         @(posedge core_clk);
         while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge core_clk);
            n = n + 1;
         end
         if (n == 20)
            chk(32'h0000_0000, 32'h0000_0001);
         rd_q = readdata;
         read <= 1'b0;
         write <= 1'b0;
      end
   endtask
   task wr(input [5:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rdc(input [5:0] a, input [31:0] exp);
      begin
         bus(1'b0, a, 32'h0000_0000);
         chk(rd_q, exp);
      end
   endtask
   // bounded wait for any element to run (0) or to freeze (1)
   task wait_bit(input want_held);
      integer n;
      begin
         n = 0;
         while ((want_held ? held_q : running_q) === 6'h00 && n < 2000) begin
            @(posedge core_clk);
            n = n + 1;
         end
      end
   endtask
   // fresh calendar second zero, window start..stop, then launch over the remote path
   task go(input [31:0] st, input [31:0] sp);
      begin
         wr(`REG_START_TIME, st);
         wr(`REG_STOP_TIME, sp);
         restart <= 1'b1;
         @(posedge core_clk);
         restart <= 1'b0;
         wr(`REG_CMD, 32'h0000_0001);
      end
   endtask
   // hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         end_of_test;
      end
   end
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      for (i = 0; i < 16; i = i + 1)
         rdc(6'(i * 4), (i == 3 || i == 5) ? {11'h000, `RST_DATE} : 32'h0000_0000);
      wr(`REG_TIMER, T_MAX);
      rdc(`REG_TIMER, T_MAX);
      wr(`REG_TIMER, T_MAX + 32'h0000_0001);
      wr(`REG_TIMER, 32'h0000_003C);
      rdc(`REG_TIMER, T_MAX);
      rdc(`REG_STATUS, 32'h0000_0008);
      chk({31'h0000_0000, irq_q}, 32'h0000_0000);
      wr(`REG_STATUS, 32'h0000_0008);
      rdc(`REG_STATUS, 32'h0000_0000);
      wr(`REG_START_TIME, 32'h0001_7EFB);
      wr(`REG_START_TIME, 32'h0001_8000);
      rdc(`REG_START_TIME, 32'h0001_7EFB);
      rdc(`REG_STATUS, 32'h0000_0008);
      wr(`REG_STATUS, 32'h0000_0008);
      wr(`REG_MASK, 32'h0000_0004);
      // february 31 is stored, then refused at launch; so is the 29th of a common year
      for (i = 0; i < 2; i = i + 1) begin
         wr(`REG_START_DATE, i ? 32'h000F_A65D : 32'h000F_A65F);
         if (i == 0)
            rdc(`REG_START_DATE, 32'h000F_A65F);
         wr(`REG_CMD, 32'h0000_0001);
         rdc(`REG_STATUS, 32'h0000_0004);
         chk({26'h000_0000, running_q}, 32'h0000_0000);
         chk({31'h0000_0000, irq_q}, 32'h0000_0001);
         wr(`REG_STATUS, 32'h0000_0004);
         rdc(`REG_STATUS, 32'h0000_0000);
         chk({31'h0000_0000, irq_q}, 32'h0000_0000);
      end
      wr(`REG_CTRL, 32'h0000_0002);
      rdc(`REG_TIMER, T_MAX);
      wr(`REG_CTRL, 32'h0000_0022);
      wr(`REG_TIMER, 32'h0000_0005);
      rdc(`REG_TIMER, 32'h0000_0005);
      wr(`REG_CTRL, 32'h0000_0032);
      rdc(`REG_TIMER, 32'h0000_0000);
      wr(`REG_CTRL, 32'h0000_0036);
      wr(`REG_TIMER, 32'h0000_0007);
      wr(`REG_CTRL, 32'h0000_0052);
      rdc(`REG_TIMER, 32'h0000_0007);
      wr(`REG_CTRL, 32'h0000_0002);
      wr(`REG_TIMER, 32'h0000_0005);
      wr(`REG_STOP_DATE, 32'h000F_A85D);
      wr(`REG_CTRL, 32'h0000_0000);
      rdc(`REG_TIMER, 32'h0000_0005);
      rdc(`REG_STOP_DATE, 32'h000F_A85D);
      wr(`REG_START_DATE, 32'h000F_A85D);
      wr(`REG_CTRL, 32'h0000_0002);
      rdc(`REG_START_DATE, 32'h000F_A85D);
      wr(`REG_CTRL, 32'h0000_0000);
      // normal run: 5 s timer inside a 10..40 s window on a leap day
      go(32'h0000_000A, 32'h0000_0028);
      chk({26'h000_0000, running_q}, 32'h0000_0000);
      wait_bit(1'b0);
      chk({31'h0000_0000, now_time >= 17'h0_000A}, 32'h0000_0001);
      wait_bit(1'b1);
      rdc(`REG_ELAPSED, 32'h0000_0005);
      rdc(`REG_VALUE, 32'h0000_000F);
      chk({26'h000_0000, held_q}, 32'h0000_003F);
      repeat (40) @(posedge core_clk);
      rdc(`REG_ELAPSED, 32'h0000_0005);
      rdc(`REG_STATUS, 32'h0000_0001);
      wr(`REG_STATUS, 32'h0000_0001);
      wr(`REG_CMD, 32'h0000_0004);
      rdc(`REG_ELAPSED, 32'h0000_0000);
      rdc(`REG_VALUE, 32'h0000_0000);
      // repetitive run: two restarts before the stop stamp
      wr(`REG_CTRL, 32'h0000_0001);
      go(32'h0000_0002, 32'h0000_0010);
      wait_bit(1'b1);
      rdc(`REG_STATUS, 32'h0000_0003);
      bus(1'b0, `REG_ELAPSED, 32'h0000_0000);
      chk({31'h0000_0000, rd_q < 32'h0000_0005}, 32'h0000_0001);
      wr(`REG_STATUS, 32'h0000_0003);
      wr(`REG_CMD, 32'h0000_0004);
      // accumulation limit, positive in normal mode with zero timer, negative repeating
      for (i = 0; i < 2; i = i + 1) begin
         wr(`REG_CTRL, i);
         wr(`REG_TIMER, i ? 32'h0000_0005 : 32'h0000_0000);
         delta <= i ? 24'hF9_E580 : 24'h06_1A80;
         go(32'h0000_0002, 32'h0000_0030);
         wait_bit(1'b1);
         rdc(`REG_VALUE, i ? 32'hFFF0_BDC1 : 32'h000F_423F);
         chk({26'h000_0000, running_q}, 32'h0000_0000);
         wr(`REG_CMD, 32'h0000_0004);
      end
      // stop command freezes a running window; values then stay put
      wr(`REG_CTRL, 32'h0000_0000);
      wr(`REG_TIMER, 32'h0000_0000);
      delta <= 24'h00_0003;
      go(32'h0000_0002, 32'h0000_0030);
      wait_bit(1'b0);
      wr(`REG_CMD, 32'h0000_0002);
      repeat (2) @(posedge core_clk);
      chk({26'h000_0000, held_q}, 32'h0000_003F);
      chk({26'h000_0000, running_q}, 32'h0000_0000);
      bus(1'b0, `REG_VALUE, 32'h0000_0000);
      repeat (24) @(posedge core_clk);
      rdc(`REG_VALUE, rd_q);
      wr(`REG_CMD, 32'h0000_0004);
      end_of_test;
   end
endmodule
